// ===== verilog/cob_pkg.sv
// Package for the converter option configuration bank
`default_nettype none
package cob_pkg;
   // ----------------------------------------
   // Command codes of the two option registers
   // ----------------------------------------
   localparam logic [7:0]  CMD_USER_OPTIONS = 8'he5;
   localparam logic [7:0]  CMD_MISC_CONFIG  = 8'hf0;
   // ----------------------------------------
   // User options field positions and values
   // ----------------------------------------
   localparam int          OPT_MHI_SEL      = 14;
   localparam int          OPT_MLO_SEL      = 13;
   localparam int          OPT_RST_VOUT     = 11;
   localparam int          OPT_RANGE_LO     = 8;
   localparam int          OPT_AUTO_ARA     = 7;
   localparam int          OPT_AVG_LO       = 5;
   localparam int          OPT_WLO          = 4;
   localparam int          OPT_VSM          = 3;
   localparam logic [15:0] OPT_RESET        = 16'h0184;
   localparam logic [15:0] OPT_WR_MASK      = 16'h6bff;
   localparam logic [15:0] OPT_FIXED_ONES   = 16'h1000;
   localparam logic [15:0] OPT_NO_NVM       = 16'h0018;
   // ----------------------------------------
   // Miscellaneous configuration layout
   // ----------------------------------------
   localparam int          MISC_SYNC_FDIS   = 8;
   localparam int          MISC_FSYNC_IN    = 7;
   localparam int          MISC_FSYNC_OUT   = 6;
   localparam int          MISC_LVL_SHIFT   = 4;
   localparam int          MISC_TRIM_LO     = 1;
   localparam int          MISC_OV_SEL      = 0;
   localparam logic [15:0] MISC_RESET       = 16'h0013;
   localparam logic [15:0] MISC_WR_MASK     = 16'h01d7;
   // ----------------------------------------
   // Margin step restore values
   // ----------------------------------------
   localparam logic [15:0] MLO_RESTORE_0    = 16'hfff7;
   localparam logic [15:0] MLO_RESTORE_1    = 16'hfff1;
   localparam logic [15:0] MHI_RESTORE_0    = 16'h0009;
   localparam logic [15:0] MHI_RESTORE_1    = 16'h000f;
   // ----------------------------------------
   // Averaging codes and measurement channels
   // ----------------------------------------
   localparam logic [1:0]  AVG_16           = 2'h0;
   localparam logic [1:0]  AVG_BYPASS       = 2'h1;
   localparam logic [1:0]  AVG_8            = 2'h2;
   localparam logic [1:0]  AVG_32           = 2'h3;
   localparam int          SMP_W            = 12;
   localparam int          ACC_W            = SMP_W + 5;
   localparam int          NCH              = 3;
   localparam logic [1:0]  CH_VOUT          = 2'h0;
   localparam int          NFAULT           = 8;
   localparam int          NSHUT            = 4;
   typedef enum logic [1:0] {
      COB_DIV_HALF,
      COB_DIV_QUARTER,
      COB_DIV_EIGHTH
   } cob_div_t;
   // All state of the bank
   typedef struct packed {
      logic [15:0]                 opt;
      logic [15:0]                 misc;
      logic [15:0]                 nv_opt;
      logic [15:0]                 nv_misc;
      logic [NCH-1:0][ACC_W-1:0]   acc;
      logic [NCH-1:0][5:0]         cnt;
      logic [NCH-1:0][SMP_W-1:0]   rdbk;
      logic [NFAULT-1:0]           amask;
      logic [15:0]                 rd_data;
      logic                        rd_valid;
      logic                        invalid_data_flag;
      logic                        rst_vout;
      logic                        vsm_q;
   } cob_state_t;
endpackage
`default_nettype wire

// ===== verilog/cob_bank.sv
// Converter option configuration bank
// Operation
// - Override bit 0 keeps write checks; 1 skips them for limited registers
// - During override invalid data to limited registers is stored without invalid flag or alert
// - Clearing the override raises no alert for stored invalid values
// - Override bit is never saved to or restored from nonvolatile store
// - Averaging code 00 gives 16, 10 gives 8, 11 gives 32 samples
// - Averaging code 01 bypasses averagers; each sample updates readback
// - Averaging defaults 00, shared by all readings, savable and restorable
// - First average after voltage-only mode change may miss one sample
// - Auto masking masks set faults after a successful alert response
// - Without auto masking faults reassert alert; host masks each source
// - Readback divider follows loop scale at 00, else forced by code
// - Restore bit resets output command on shutdown, restart or low input
// - Margin-low restore select picks fff7h or fff1h
// - Margin-high restore select picks 0009h or 000fh
// - Misc register holds sync, level shift, trim and overvoltage fields
// - Misc register is saved on store-all and restored afterwards
// - Voltage-only mode stops current and temperature readback updates
`default_nettype none
module cob_bank (
   // Clock and reset
   input  wire logic                       clk_sys_in,
   input  wire logic                       reset_n_in,
   // Register access from the bus command decoder
   input  wire logic                       wr_en_in,
   input  wire logic                       rd_en_in,
   input  wire logic [7:0]                 cmd_in,
   input  wire logic [15:0]                wr_data_in,
   output var  logic [15:0]                rd_data_out,
   output var  logic                       rd_valid_out,
   // Limit checking of writes to other registers
   input  wire logic                       chk_wr_in,
   input  wire logic                       chk_limited_in,
   input  wire logic                       chk_invalid_in,
   output logic                            chk_allow_out,
   output var  logic                       invalid_data_flag_out,
   // Nonvolatile store and restore
   input  wire logic                       store_all_in,
   input  wire logic                       restore_all_in,
   // Measurement samples
   input  wire logic                       smp_valid_in,
   input  wire logic [1:0]                 smp_ch_in,
   input  wire logic [cob_pkg::SMP_W-1:0]  smp_data_in,
   output var  logic [cob_pkg::SMP_W-1:0]  read_vout_out,
   output var  logic [cob_pkg::SMP_W-1:0]  read_iout_out,
   output var  logic [cob_pkg::SMP_W-1:0]  read_temp_out,
   output var  logic                       voltage_only_measure_out,
   // Alert masking
   input  wire logic [cob_pkg::NFAULT-1:0] fault_active_in,
   input  wire logic [cob_pkg::NFAULT-1:0] host_mask_in,
   input  wire logic                       ara_done_in,
   input  wire logic                       clear_faults_in,
   output logic                            alert_out,
   // Output voltage readback divider
   input  wire logic [1:0]                 loop_scale_in,
   output cob_pkg::cob_div_t               vout_readback_divider_out,
   // Output command restore and margin restore values
   input  wire logic [cob_pkg::NSHUT-1:0]  shutdown_event_in,
   output var  logic                       vout_cmd_restore_out,
   output logic [15:0]                     margin_low_restore_out,
   output logic [15:0]                     margin_high_restore_out,
   // Miscellaneous configuration fields
   output logic                            clock_sync_fault_disable_out,
   output logic                            force_sync_in_out,
   output logic                            force_sync_out_out,
   output logic                            comp_level_shift_enable_out,
   output logic [1:0]                      high_side_current_trim_out,
   output logic                            overvoltage_low_fet_select_out
);
   import cob_pkg::*;

   cob_state_t st;
   cob_state_t next_st;

   logic       wlo;
   logic       voltage_only_measure;
   logic [1:0] avg_sel;
   logic [5:0] avg_n;
   logic [2:0] avg_sh;
   logic [15:0] opt_rd;

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   assign wlo     = st.opt[OPT_WLO];
   assign voltage_only_measure     = st.opt[OPT_VSM];
   assign avg_sel = st.opt[OPT_AVG_LO +: 2];
   assign opt_rd  = st.opt | OPT_FIXED_ONES;

   // Sample count and shift per averaging code
   always_comb begin
      case (avg_sel)
         AVG_16: begin
            avg_n  = 6'h10;
            avg_sh = 3'h4;
         end
         AVG_8: begin
            avg_n  = 6'h08;
            avg_sh = 3'h3;
         end
         AVG_32: begin
            avg_n  = 6'h20;
            avg_sh = 3'h5;
         end
         default: begin
            avg_n  = 6'h01;
            avg_sh = 3'h0;
         end
      endcase
   end

   // Divider choice: follows loop scale at 00, forced otherwise
   always_comb begin
      case (st.opt[OPT_RANGE_LO +: 2])
         2'h3:    vout_readback_divider_out = COB_DIV_HALF;
         2'h2:    vout_readback_divider_out = COB_DIV_QUARTER;
         2'h1:    vout_readback_divider_out = COB_DIV_EIGHTH;
         default: begin
            case (loop_scale_in)
               2'h1:    vout_readback_divider_out = COB_DIV_QUARTER;
               2'h2:    vout_readback_divider_out = COB_DIV_EIGHTH;
               default: vout_readback_divider_out = COB_DIV_HALF;
            endcase
         end
      endcase
   end

   // Write gate: override lets invalid data through to limited registers only
   assign chk_allow_out = !chk_invalid_in || (wlo && chk_limited_in);

   // Alert only from unmasked active faults; no term on override change
   assign alert_out = |(fault_active_in & ~(st.amask | host_mask_in));

   // Margin restore values
   assign margin_low_restore_out  = st.opt[OPT_MLO_SEL] ? MLO_RESTORE_1
                                                        : MLO_RESTORE_0;
   assign margin_high_restore_out = st.opt[OPT_MHI_SEL] ? MHI_RESTORE_1
                                                        : MHI_RESTORE_0;

   // Miscellaneous fields
   assign clock_sync_fault_disable_out   = st.misc[MISC_SYNC_FDIS];
   assign force_sync_in_out              = st.misc[MISC_FSYNC_IN];
   assign force_sync_out_out             = st.misc[MISC_FSYNC_OUT];
   assign comp_level_shift_enable_out    = st.misc[MISC_LVL_SHIFT];
   assign high_side_current_trim_out     = st.misc[MISC_TRIM_LO +: 2];
   assign overvoltage_low_fet_select_out = st.misc[MISC_OV_SEL];

   // Registered outputs
   assign rd_data_out              = st.rd_data;
   assign rd_valid_out             = st.rd_valid;
   assign invalid_data_flag_out    = st.invalid_data_flag;
   assign vout_cmd_restore_out     = st.rst_vout;
   assign voltage_only_measure_out = voltage_only_measure;
   assign read_vout_out            = st.rdbk[0];
   assign read_iout_out            = st.rdbk[1];
   assign read_temp_out            = st.rdbk[2];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [ACC_W-1:0] sum;
      logic             avg_chg;
      sum     = '0;
      avg_chg = 1'b0;
      next_st = st;
      // Register writes and nonvolatile restore
      if (restore_all_in) begin
         next_st.opt  = st.nv_opt;
         next_st.misc = st.nv_misc;
      end else if (wr_en_in && cmd_in == CMD_USER_OPTIONS) begin
         next_st.opt = wr_data_in & OPT_WR_MASK;
      end else if (wr_en_in && cmd_in == CMD_MISC_CONFIG) begin
         next_st.misc = wr_data_in & MISC_WR_MASK;
      end
      // Store drops override and voltage-only bits
      if (store_all_in) begin
         next_st.nv_opt  = st.opt & ~OPT_NO_NVM;
         next_st.nv_misc = st.misc;
      end
      // Register reads, unmapped codes answer zero
      next_st.rd_valid = rd_en_in;
      if (rd_en_in) begin
         case (cmd_in)
            CMD_USER_OPTIONS: next_st.rd_data = opt_rd;
            CMD_MISC_CONFIG:  next_st.rd_data = st.misc;
            default:          next_st.rd_data = 16'h0000;
         endcase
      end
      // Invalid flag pulse unless override covers a limited register
      next_st.invalid_data_flag = chk_wr_in && !chk_allow_out;
      // Output command restore on shutdown events
      next_st.rst_vout = st.opt[OPT_RST_VOUT] && (|shutdown_event_in);
      // Auto mask after alert response; set wins over clear
      if (clear_faults_in) begin
         next_st.amask = '0;
      end
      if (ara_done_in && st.opt[OPT_AUTO_ARA]) begin
         next_st.amask = next_st.amask | fault_active_in;
      end
      // Averagers also restart on an averaging code change, since a partial
      // sum taken under the old count would be scaled by the wrong shift
      avg_chg = next_st.opt[OPT_AVG_LO +: 2] != avg_sel;
      // Averagers restart when voltage-only mode changes
      next_st.vsm_q = voltage_only_measure;
      for (int c = 0; c < NCH; c++) begin
         if (voltage_only_measure != st.vsm_q || avg_chg) begin
            next_st.acc[c] = '0;
            next_st.cnt[c] = '0;
         end else if (smp_valid_in && smp_ch_in == c[1:0]
                      && (smp_ch_in == CH_VOUT || !voltage_only_measure)) begin
            sum = st.acc[c] + {{(ACC_W-SMP_W){1'b0}}, smp_data_in};
            if (st.cnt[c] + 6'h01 >= avg_n) begin
               next_st.rdbk[c] = SMP_W'(sum >> avg_sh);
               next_st.acc[c]  = '0;
               next_st.cnt[c]  = '0;
            end else begin
               next_st.acc[c] = sum;
               next_st.cnt[c] = st.cnt[c] + 6'h01;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st         <= '0;
         st.opt     <= OPT_RESET;
         st.misc    <= MISC_RESET;
         st.nv_opt  <= OPT_RESET;
         st.nv_misc <= MISC_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);

   wlo_no_flag_a: assert property (wlo && chk_limited_in |-> ##1 !st.invalid_data_flag)
      else $error("invalid flag raised under override");
   chk_flag_a: assert property (chk_wr_in && chk_invalid_in && !wlo |=> st.invalid_data_flag)
      else $error("invalid write not flagged");
   wlo_clear_a: assert property ($fell(wlo) && fault_active_in == '0 |-> !alert_out)
      else $error("alert on override clear");
   wlo_store_a: assert property (store_all_in |=> !st.nv_opt[OPT_WLO])
      else $error("override bit stored");
   avg16_a: assert property (avg_sel == AVG_16 |-> avg_n == 6'h10 && avg_sh == 3'h4)
      else $error("wrong 16 sample average");
   bypass_a: assert property (smp_valid_in && smp_ch_in == CH_VOUT && avg_sel == AVG_BYPASS
                              && voltage_only_measure == st.vsm_q && !wr_en_in && !restore_all_in
                              |=> read_vout_out == $past(smp_data_in))
      else $error("bypass sample not passed");
   ara_mask_a: assert property (ara_done_in && st.opt[OPT_AUTO_ARA] && !clear_faults_in
                                |=> (st.amask & $past(fault_active_in))
                                    == $past(fault_active_in))
      else $error("faults not masked after alert response");
   no_auto_a: assert property (!st.opt[OPT_AUTO_ARA] && !clear_faults_in
                               |=> st.amask == $past(st.amask))
      else $error("mask changed without auto masking");
   rst_vout_a: assert property (st.opt[OPT_RST_VOUT] && |shutdown_event_in
                                |=> vout_cmd_restore_out ##1 !vout_cmd_restore_out
                                    || $past(|shutdown_event_in, 1))
      else $error("output command restore missing");
   mlo_a: assert property (margin_low_restore_out
                           == (st.opt[OPT_MLO_SEL] ? 16'hfff1 : 16'hfff7))
      else $error("wrong margin low restore");
   mhi_a: assert property (margin_high_restore_out
                           == (st.opt[OPT_MHI_SEL] ? 16'h000f : 16'h0009))
      else $error("wrong margin high restore");
   misc_rd_a: assert property ((st.misc & ~MISC_WR_MASK) == 16'h0000)
      else $error("misc reserved bit set");
   misc_nv_a: assert property (store_all_in ##1 restore_all_in
                               |=> st.misc == $past(st.misc, 2))
      else $error("misc not restored");
   vsm_hold_a: assert property (voltage_only_measure && voltage_only_measure == st.vsm_q |=> $stable(read_iout_out)
                                && $stable(read_temp_out))
      else $error("current reading updated in voltage-only mode");
   // Restart, mask priority, restore and read answer guards
   avg_chg_a: assert property (wr_en_in && cmd_in == CMD_USER_OPTIONS && !restore_all_in
                               && wr_data_in[OPT_AVG_LO +: 2] != avg_sel |=> st.cnt == '0)
      else $error("averagers kept partial sum over code change");
   ara_wins_a: assert property (ara_done_in && st.opt[OPT_AUTO_ARA] && clear_faults_in
                                |=> st.amask == $past(fault_active_in))
      else $error("clear beat alert response mask");
   wlo_restore_a: assert property (restore_all_in |=> !st.opt[OPT_WLO])
      else $error("override bit restored");
   rst_idle_a: assert property (!st.opt[OPT_RST_VOUT] |=> !vout_cmd_restore_out)
      else $error("output command restore while disabled");
   rd_valid_a: assert property (rd_en_in |=> rd_valid_out)
      else $error("read answer missing");

   ara_c:    cover property (ara_done_in && st.opt[OPT_AUTO_ARA] && |fault_active_in);
   wlo_c:    cover property (chk_wr_in && chk_invalid_in && wlo && chk_limited_in);
   avg32_c:  cover property (avg_sel == AVG_32 && st.rdbk[0] != '0);
   restore_c: cover property (store_all_in ##[1:20] restore_all_in);
endmodule
`default_nettype wire

// ===== test/cob_host_model.sv
// Host side model issuing register reads and writes to the option bank
`default_nettype none
module cob_host_model (
   // Clock
   input  wire logic        clk_sys_in,
   // Answer from the bank
   input  wire logic [15:0] rd_data_in,
   input  wire logic        rd_valid_in,
   // Request to the bank
   output logic             wr_en_out,
   output logic             rd_en_out,
   output logic [7:0]       cmd_out,
   output logic [15:0]      wr_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero
   initial begin
      wr_en_out   = 1'b0;
      rd_en_out   = 1'b0;
      cmd_out     = 8'h00;
      wr_data_out = 16'h0000;
   end
   // One write strobe; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      @(posedge clk_sys_in);
      wr_en_out   <= 1'b1;
      cmd_out     <= cmd;
      wr_data_out <= data;
      @(posedge clk_sys_in);
      wr_en_out   <= 1'b0;
      cmd_out     <= ~cmd;
      wr_data_out <= ~data;
   endtask
   // One read strobe, then wait a bounded time for the valid pulse
   task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
      ok   = 1'b0;
      data = 16'h0000;
      @(posedge clk_sys_in);
      rd_en_out <= 1'b1;
      cmd_out   <= cmd;
      @(posedge clk_sys_in);
      rd_en_out <= 1'b0;
      cmd_out   <= ~cmd;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge clk_sys_in);
         if (rd_valid_in === 1'b1) begin
            ok   = 1'b1;
            data = rd_data_in;
         end
      end
   endtask
endmodule
`default_nettype wire

// ===== test/test_cob_bank.sv
// Self-checking testbench of the converter option configuration bank
`default_nettype none
module test_cob_bank;
   timeunit 1ns;
   timeprecision 1ns;
   import cob_pkg::*;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic              clk_sys_in = 1'b0, reset_n_in = 1'b0;
   logic              wr_en, rd_en, rd_valid, chk_wr = 1'b0, chk_lim = 1'b0, chk_inv = 1'b0;
   logic              store = 1'b0, restore = 1'b0, smp_valid = 1'b0, ara = 1'b0, clr = 1'b0;
   logic              allow, invalid_data_flag, voltage_only_measure, alert, vrst, sfd, fin, fout, lvl, ovs;
   logic [7:0]        cmd, fault = 8'h00, hmask = 8'h00;
   logic [15:0]       wr_data, rd_data, mlo, mhi;
   logic [1:0]        smp_ch = 2'h0, lscale = 2'h0, trim;
   logic [11:0]       smp_data = 12'h000, rvout, riout, rtemp;
   logic [3:0]        shut = 4'h0;
   cob_div_t          div;
   int                error_cnt = 0, n_checks = 0;
   logic [1:0]        codes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   int                ns    [4] = '{16, 8, 32, 1};
   // Clock of 100 ns period
   always #50 clk_sys_in = ~clk_sys_in;
   cob_bank uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .cmd_in(cmd), .wr_data_in(wr_data), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .chk_wr_in(chk_wr), .chk_limited_in(chk_lim),
      .chk_invalid_in(chk_inv), .chk_allow_out(allow), .invalid_data_flag_out(invalid_data_flag),
      .store_all_in(store), .restore_all_in(restore), .smp_valid_in(smp_valid),
      .smp_ch_in(smp_ch), .smp_data_in(smp_data), .read_vout_out(rvout),
      .read_iout_out(riout), .read_temp_out(rtemp), .voltage_only_measure_out(voltage_only_measure),
      .fault_active_in(fault), .host_mask_in(hmask), .ara_done_in(ara),
      .clear_faults_in(clr), .alert_out(alert), .loop_scale_in(lscale),
      .vout_readback_divider_out(div), .shutdown_event_in(shut),
      .vout_cmd_restore_out(vrst), .margin_low_restore_out(mlo),
      .margin_high_restore_out(mhi), .clock_sync_fault_disable_out(sfd),
      .force_sync_in_out(fin), .force_sync_out_out(fout),
      .comp_level_shift_enable_out(lvl), .high_side_current_trim_out(trim),
      .overvoltage_low_fet_select_out(ovs));
   cob_host_model host (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data),
      .rd_valid_in(rd_valid), .wr_en_out(wr_en), .rd_en_out(rd_en), .cmd_out(cmd),
      .wr_data_out(wr_data));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] c, input logic [15:0] exp, input string msg);
      logic [15:0] d;
      logic        ok;
      host.rd(c, d, ok);
      chk({15'h0, ok}, 16'h0001, "read answer");
      chk(d, exp, msg);
   endtask
   task automatic smp(input logic [1:0] ch, input logic [11:0] v);
      @(posedge clk_sys_in);
      smp_valid <= 1'b1;
      smp_ch    <= ch;
      smp_data  <= v;
      @(posedge clk_sys_in);
      smp_valid <= 1'b0;
      smp_data  <= ~v;
      @(negedge clk_sys_in);
   endtask
   task automatic wchk(input logic inv, input logic lim, input logic ea, input logic ef);
      @(posedge clk_sys_in);
      chk_wr  <= 1'b1;
      chk_inv <= inv;
      chk_lim <= lim;
      @(negedge clk_sys_in);
      chk({15'h0, allow}, {15'h0, ea}, "write allow");
      @(posedge clk_sys_in);
      chk_wr <= 1'b0;
      @(negedge clk_sys_in);
      chk({15'h0, invalid_data_flag}, {15'h0, ef}, "invalid flag");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #2000000;
      error_cnt++;
      final_report();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [11:0] v;
      repeat (4) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      rdchk(CMD_USER_OPTIONS, 16'h1184, "options reset");
      rdchk(CMD_MISC_CONFIG, 16'h0013, "misc reset");
      rdchk(8'h00, 16'h0000, "unmapped read");
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         if (k > 0) host.wr(CMD_USER_OPTIONS, 16'h0184 | {9'h0, codes[k], 5'h0});
         for (int i = 0; i < ns[k]; i++) begin
            v = 12'h100 + 12'(2 * i);
            smp(2'h0, v);
         end
         chk({4'h0, rvout}, 16'h0100 + 16'(ns[k] - 1), "averaged vout");
      end
      smp(2'h1, 12'h055);
      chk({4'h0, riout}, 16'h0055, "bypass iout");
      smp(2'h2, 12'h033);
      chk({4'h0, rtemp}, 16'h0033, "bypass temp");
      host.wr(CMD_USER_OPTIONS, 16'h01ac);
      @(negedge clk_sys_in);
      chk({15'h0, voltage_only_measure}, 16'h0001, "voltage only bit");
      smp(2'h1, 12'h0aa);
      chk({4'h0, riout}, 16'h0055, "iout frozen");
      smp(2'h2, 12'h0cc);
      chk({4'h0, rtemp}, 16'h0033, "temp frozen");
      smp(2'h0, 12'h0ab);
      chk({4'h0, rvout}, 16'h00ab, "vout in voltage only");
      $display("test averaging done");
      host.wr(CMD_USER_OPTIONS, 16'h01a4);
      wchk(1'b1, 1'b1, 1'b0, 1'b1);
      wchk(1'b0, 1'b1, 1'b1, 1'b0);
      host.wr(CMD_USER_OPTIONS, 16'h01b4);
      wchk(1'b1, 1'b1, 1'b1, 1'b0);
      rdchk(CMD_USER_OPTIONS, 16'h11b4, "override set");
      host.wr(CMD_USER_OPTIONS, 16'h01a4);
      @(negedge clk_sys_in);
      chk({15'h0, alert}, 16'h0000, "no alert on override exit");
      chk({15'h0, invalid_data_flag}, 16'h0000, "no flag on override exit");
      $display("test override done");
      host.wr(CMD_USER_OPTIONS, 16'h6bff);
      host.wr(CMD_MISC_CONFIG, 16'hffff);
      chk(mlo, MLO_RESTORE_1, "margin low sel 1");
      chk(mhi, MHI_RESTORE_1, "margin high sel 1");
      rdchk(CMD_MISC_CONFIG, 16'h01d7, "misc fields");
      chk({9'h0, sfd, fin, fout, lvl, trim, ovs}, 16'h007f, "misc outputs");
      @(posedge clk_sys_in) store <= 1'b1;
      @(posedge clk_sys_in) store <= 1'b0;
      host.wr(CMD_USER_OPTIONS, 16'h0000);
      host.wr(CMD_MISC_CONFIG, 16'h0000);
      @(negedge clk_sys_in);
      chk(mlo, MLO_RESTORE_0, "margin low sel 0");
      chk(mhi, MHI_RESTORE_0, "margin high sel 0");
      chk({9'h0, sfd, fin, fout, lvl, trim, ovs}, 16'h0000, "misc cleared");
      @(posedge clk_sys_in) restore <= 1'b1;
      @(posedge clk_sys_in) restore <= 1'b0;
      rdchk(CMD_USER_OPTIONS, 16'h7be7, "options restored");
      rdchk(CMD_MISC_CONFIG, 16'h01d7, "misc restored");
      $display("test store done");
      for (int r = 0; r < 4; r++) begin
         host.wr(CMD_USER_OPTIONS, {6'h0, 2'(r), 8'h84});
         for (int ls = 0; ls < 3; ls++) begin
            @(posedge clk_sys_in) lscale <= 2'(ls);
            @(negedge clk_sys_in);
            chk({14'h0, div}, (r == 0) ? 16'(ls) : 16'(3 - r), "divider");
         end
      end
      $display("test divider done");
      host.wr(CMD_USER_OPTIONS, 16'h0884);
      for (int e = 0; e < 5; e++) begin
         if (e == 4) host.wr(CMD_USER_OPTIONS, 16'h0084);
         @(posedge clk_sys_in) shut <= 4'h1 << (e % 4);
         @(posedge clk_sys_in) shut <= 4'h0;
         @(negedge clk_sys_in);
         chk({15'h0, vrst}, {15'h0, e < 4}, "restore pulse");
         @(negedge clk_sys_in);
         chk({15'h0, vrst}, 16'h0000, "restore pulse end");
      end
      $display("test shutdown done");
      @(posedge clk_sys_in) fault <= 8'h05;
      @(negedge clk_sys_in) chk({15'h0, alert}, 16'h0001, "fault alert");
      @(posedge clk_sys_in) ara <= 1'b1;
      @(posedge clk_sys_in) ara <= 1'b0;
      @(negedge clk_sys_in) chk({15'h0, alert}, 16'h0000, "auto masked");
      @(posedge clk_sys_in) fault <= 8'h0d;
      @(negedge clk_sys_in) chk({15'h0, alert}, 16'h0001, "new source alert");
      @(posedge clk_sys_in) clr <= 1'b1;
      @(posedge clk_sys_in) clr <= 1'b0;
      host.wr(CMD_USER_OPTIONS, 16'h0004);
      @(posedge clk_sys_in) ara <= 1'b1;
      @(posedge clk_sys_in) ara <= 1'b0;
      @(negedge clk_sys_in) chk({15'h0, alert}, 16'h0001, "alert reasserts");
      @(posedge clk_sys_in) hmask <= 8'h0d;
      @(negedge clk_sys_in) chk({15'h0, alert}, 16'h0000, "host masked");
      $display("test alert done");
      final_report();
   end
endmodule
`default_nettype wire
